// ==== pkg/vls_pkg.sv ====
// Purpose: Shared constants for the vector memory access checker.
// Assumes: Byte-addressed 64-bit addresses, 32-bit AHB-Lite register bus.
// Notes:   Register offsets are word aligned byte addresses.
`default_nettype none
package vls_pkg;
  localparam int ADDR_W = 64;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_ADDR_LO = 8'h04;
  localparam logic [7:0] OFF_ADDR_HI = 8'h08;
  localparam logic [7:0] OFF_OP      = 8'h0c;
  localparam logic [7:0] OFF_PRED    = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  localparam logic [7:0] OFF_DATA    = 8'h18;
  localparam logic [7:0] OFF_RESULT  = 8'h1c;
  localparam logic [7:0] OFF_FFMASK  = 8'h20;
  // CTRL fields
  localparam int CTRL_ALIGN_BIT = 0;
  localparam int CTRL_SPCHK_BIT = 1;
  localparam int CTRL_BIGEND_BIT = 2;
  // OP fields
  localparam int OP_KIND_LSB = 0;   // 3 bits
  localparam int OP_SIZE_LSB = 4;   // 2 bits log2 memory access size
  localparam int OP_SIGNED_BIT = 6;
  localparam int OP_SPBASE_BIT = 7;
  localparam int OP_DEVICE_BIT = 8;
  localparam int OP_NT_BIT = 9;
  localparam int OP_GATHER_BIT = 10;
  localparam int OP_STORE_BIT = 11;
  localparam int OP_CROSS_BIT = 12;  // Element access crosses a type boundary
  localparam int OP_START_BIT = 31;
  // STATUS fields
  localparam int ST_ALIGN_BIT = 0;
  localparam int ST_SUPP_BIT  = 1;
  localparam int ST_ISSUE_BIT = 2;
  localparam int ST_UNPRED_BIT = 3;
  localparam int ST_WIN_LSB   = 8;   // 8 bits speculative window mask
  // Alignment masks
  localparam logic [ADDR_W-1:0] VEC_ALIGN_MASK  = 64'h000000000000000f;
  localparam logic [ADDR_W-1:0] PRED_ALIGN_MASK = 64'h0000000000000001;
  localparam logic [ADDR_W-1:0] SP_ALIGN_MASK   = 64'h000000000000000f;
  localparam logic [ADDR_W-1:0] WIN64_MASK      = 64'hffffffffffffffc0;
  localparam logic [ADDR_W-1:0] WIN128_MASK     = 64'hffffffffffffff80;
  localparam int PRED_GROUP_BITS = 8;
  typedef enum logic [2:0] {
    K_PRED_ELEM, K_UNPRED_VEC, K_UNPRED_PRED, K_PREFETCH, K_NONFAULT, K_FIRSTFAULT
  } kind_e;
endpackage : vls_pkg
`default_nettype wire

// ==== rtl/vls_check.sv ====
// Purpose: Per-element access checker for a vector load/store unit.
// Assumes: Software presents one element at a time over AHB-Lite.
// Notes:   Issue, fault and suppression decisions are registered.
//
// Chosen here: the AHB-Lite slave port and the address map.
`default_nettype none
module vls_check
  import vls_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  logic [2:0]        system_control_register;
  logic [31:0]       addr_lo_reg;
  logic [31:0]       addr_hi_reg;
  logic [31:0]       op_reg;
  logic              active_reg;
  logic              first_active_reg;
  logic [31:0]       status_reg;
  logic [31:0]       data_reg;
  logic [31:0]       result_reg;
  logic [31:0]       first_fault_mask_register;
  logic [4:0]        elem_idx_reg;
  logic              ff_first_done_reg;
  logic              wr_pend_reg;
  logic [7:0]        wr_off_reg;
  logic              go_reg;

  // Byte reversal over the low 1, 2 or 4 bytes
  function automatic logic [31:0] swap_bytes(input logic [31:0] d, input logic [1:0] sz);
    logic [31:0] r;
    r = d;
    unique case (sz)
      2'd1: r = {16'h0000, d[7:0], d[15:8]};
      2'd2, 2'd3: r = {d[7:0], d[15:8], d[23:16], d[31:24]};
      default: r = {24'h000000, d[7:0]};
    endcase
    return r;
  endfunction : swap_bytes

  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    logic [31:0] r;
    unique case (sz)
      2'd0: r = 32'h000000ff;
      2'd1: r = 32'h0000ffff;
      default: r = 32'hffffffff;
    endcase
    return r;
  endfunction : size_mask

  // AHB address phase capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_reg <= 1'b0;
      wr_off_reg  <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      wr_off_reg  <= haddr[7:0];
    end
  end

  logic [ADDR_W-1:0] addr;
  kind_e             kind;
  logic [1:0]        msz;
  logic              dev;
  logic              chk_on;
  logic              misal;
  logic              stack_misal;
  logic              align_fault;
  logic              suppress;
  logic              ff_record;
  logic              issue;
  logic              byte_mode;
  logic              unpred;
  logic [7:0]        win_mask;
  logic [ADDR_W-1:0] msz_mask;
  logic [31:0]       load_val;
  logic [31:0]       store_val;

  assign addr = {addr_hi_reg, addr_lo_reg};
  assign kind = kind_e'(op_reg[OP_KIND_LSB +: 3]);
  assign msz  = op_reg[OP_SIZE_LSB +: 2];
  assign dev  = op_reg[OP_DEVICE_BIT];
  assign msz_mask = (ADDR_W'(1) << msz) - ADDR_W'(1);
  assign chk_on = system_control_register[CTRL_ALIGN_BIT] || dev;

  always_comb begin
    misal = 1'b0;
    unique case (kind)
      K_UNPRED_VEC:  misal = |(addr & VEC_ALIGN_MASK);
      K_UNPRED_PRED: misal = |(addr & PRED_ALIGN_MASK);
      K_PREFETCH:    misal = 1'b0;
      default:       misal = active_reg && |(addr & msz_mask);
    endcase
  end

  // Stack check applies regardless of active elements
  assign stack_misal = op_reg[OP_SPBASE_BIT] && system_control_register[CTRL_SPCHK_BIT]
                       && |(addr & SP_ALIGN_MASK);
  assign align_fault = (chk_on && misal) || stack_misal;

  always_comb begin
    suppress = 1'b0;
    unique case (kind)
      K_PREFETCH:   suppress = dev;
      K_NONFAULT:   suppress = dev && active_reg;
      // The done flag may be left over from an earlier load, so a first element ignores it
      K_FIRSTFAULT: suppress = dev && active_reg && ff_first_done_reg
                               && !first_active_reg;
      default:      suppress = 1'b0;
    endcase
  end

  // Prefetches are hints only and never leave a mark in the mask
  assign ff_record = suppress && (kind != K_PREFETCH);

  // Unpredicated forms are pure byte streams; predicated aligned ones go whole
  assign byte_mode = (kind == K_UNPRED_VEC) || (kind == K_UNPRED_PRED);
  assign issue = !align_fault && !suppress && (active_reg || byte_mode)
                 && kind != K_PREFETCH;
  assign unpred = op_reg[OP_CROSS_BIT] && (byte_mode || active_reg);

  // Speculative window: 8 lanes of 64 or 16 of 128; report the lane holding the address, or the half picked by addr[7]
  always_comb begin
    win_mask = 8'h00;
    if (dev && issue && !op_reg[OP_STORE_BIT]) begin
      if (op_reg[OP_NT_BIT] && op_reg[OP_GATHER_BIT])
        win_mask = addr[7] ? 8'hf0 : 8'h0f;
      else
        win_mask = 8'h01 << addr[5:3];
    end
  end

  // Loads swap then extend; stores truncate then swap
  always_comb begin
    logic [31:0] sw;
    logic [31:0] m;
    sw = 32'h00000000;
    m = size_mask(msz);
    if (byte_mode) begin
      load_val  = data_reg;
      store_val = data_reg;
    end else begin
      sw = system_control_register[CTRL_BIGEND_BIT] ? swap_bytes(data_reg, msz)
                                                   : data_reg & m;
      load_val = sw & m;
      if (op_reg[OP_SIGNED_BIT]) begin
        unique case (msz)
          2'd0: load_val = {{24{sw[7]}}, sw[7:0]};
          2'd1: load_val = {{16{sw[15]}}, sw[15:0]};
          default: load_val = sw;
        endcase
      end
      store_val = system_control_register[CTRL_BIGEND_BIT] ?
                  swap_bytes(data_reg & m, msz) : data_reg & m;
    end
  end

  // Write strobe for one register, valid in the data phase of a write
  function automatic logic wr_hit(input logic       pend,
                                  input logic [7:0] off,
                                  input logic [7:0] target);
    return pend && (off == target);
  endfunction : wr_hit

  // Control bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      system_control_register <= 3'h0;
    end else if (wr_hit(wr_pend_reg, wr_off_reg, OFF_CTRL)) begin
      system_control_register <= hwdata[2:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_lo_reg <= 32'h00000000;
    end else if (wr_hit(wr_pend_reg, wr_off_reg, OFF_ADDR_LO)) begin
      addr_lo_reg <= hwdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_hi_reg <= 32'h00000000;
    end else if (wr_hit(wr_pend_reg, wr_off_reg, OFF_ADDR_HI)) begin
      addr_hi_reg <= hwdata;
    end
  end

  // Start strobe lasts one cycle; the command stays readable afterwards
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_reg <= 32'h00000000;
      go_reg <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (wr_hit(wr_pend_reg, wr_off_reg, OFF_OP)) begin
        op_reg <= hwdata;
        go_reg <= hwdata[OP_START_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_reg       <= 1'b0;
      first_active_reg <= 1'b0;
    end else if (wr_hit(wr_pend_reg, wr_off_reg, OFF_PRED)) begin
      active_reg       <= hwdata[0];
      first_active_reg <= hwdata[1];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_reg <= 32'h00000000;
    end else if (wr_hit(wr_pend_reg, wr_off_reg, OFF_DATA)) begin
      data_reg <= hwdata;
    end
  end

  // Status of the latest evaluation, one per start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= 32'h00000000;
    end else if (go_reg) begin
      status_reg <= 32'h00000000;
      status_reg[ST_ALIGN_BIT] <= align_fault;
      status_reg[ST_SUPP_BIT]  <= suppress;
      status_reg[ST_ISSUE_BIT] <= issue;
      status_reg[ST_UNPRED_BIT] <= unpred;
      status_reg[ST_WIN_LSB +: 8] <= win_mask;
    end
  end

  // Stores issue in call order, so same-location writes stay ascending
  // A suppressed or faulted element keeps the old result value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_reg <= 32'h00000000;
    end else if (go_reg && issue) begin
      result_reg <= op_reg[OP_STORE_BIT] ? store_val : load_val;
    end
  end

  // A first element opens a fresh mask; later suppressed elements other than prefetches clear their bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_fault_mask_register <= 32'hffffffff;
    end else if (go_reg && first_active_reg) begin
      first_fault_mask_register <= ff_record ? 32'hfffffffe : 32'hffffffff;
    end else if (go_reg && ff_record) begin
      first_fault_mask_register[elem_idx_reg] <= 1'b0;
    end
  end

  // Index wraps after 32 elements; longer vectors reuse mask bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      elem_idx_reg <= 5'h00;
    end else if (go_reg) begin
      elem_idx_reg <= first_active_reg ? 5'h01 : elem_idx_reg + 5'h01;
    end
  end

  // Set by a first element that is active without a fault, or by any later active first-fault element
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff_first_done_reg <= 1'b0;
    end else if (go_reg && first_active_reg) begin
      ff_first_done_reg <= active_reg && !align_fault;
    end else if (go_reg && active_reg && kind == K_FIRSTFAULT) begin
      ff_first_done_reg <= 1'b1;
    end
  end

  // Read data, registered in data phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        OFF_CTRL:    hrdata <= {29'h0, system_control_register};
        OFF_ADDR_LO: hrdata <= addr_lo_reg;
        OFF_ADDR_HI: hrdata <= addr_hi_reg;
        OFF_OP:      hrdata <= op_reg;
        OFF_PRED:    hrdata <= {30'h0, first_active_reg, active_reg};
        OFF_STATUS:  hrdata <= status_reg;
        OFF_DATA:    hrdata <= data_reg;
        OFF_RESULT:  hrdata <= result_reg;
        OFF_FFMASK:  hrdata <= first_fault_mask_register;
        default:     hrdata <= 32'h00000000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : vls_check
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the vector access checker.
// Assumes: Zero wait state slave; one idle cycle before status reads.
// Notes:   Each read queues a note; the monitor compares it at the data edge.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vls_pkg::*;
  typedef struct {string nm; logic [31:0] ex; logic [31:0] mk;} note_s;
  note_s            q[$];
  note_s            n;
  logic             clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
  logic [31:0]      haddr = '0, hwdata = '0, mem_addr = '0, d, lo;
  logic [1:0]       htrans = 2'b00;
  logic [2:0]       hsize = 3'b010, k;
  logic [3:0]       m;
  logic             f;
  wire logic [31:0] hrdata, mem_data;
  wire logic        hready, hresp;
  int               bad_count = 0, checks = 0, cyc = 0, seed = 98054, be, st, sg, s;
  vls_check DUT (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp);
  vls_memory_model mem (.addr(mem_addr), .data(mem_data));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  always @(posedge clk) begin
    rd_ph <= hsel && htrans[1] && !hwrite;
    if (rd_ph) begin
      n = q.pop_front();
      checks++;
      if ((hrdata & n.mk) !== (n.ex & n.mk)) begin
        bad_count++;
        $display("wrong value %s expected %h seen %h", n.nm, n.ex & n.mk, hrdata & n.mk);
      end
      checks++;
      if (hresp !== 1'b0) begin
        bad_count++;
        $display("wrong value hresp expected 0 seen %b", hresp);
      end
    end
  end
  function automatic logic [31:0] want(input int k, be, st, sg, s, input logic [31:0] v);
    logic [31:0] t;
    int          w;
    w = 1 << s;
    t = '0;
    if (k != 0) return v;
    for (int i = 0; i < w; i++) t[8*i +: 8] = be ? v[8*(w-1-i) +: 8] : v[8*i +: 8];
    if (!st && sg && t[8*w-1]) t = t | ~((32'h1 << (8*w)) - 1);
    return t;
  endfunction : want
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= v;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
  endtask : xfer
  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] ex, mk);
    q.push_back('{nm, ex, mk});
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic run(input logic [31:0] c, a, p, v, o);
    xfer(1'b1, OFF_CTRL, c);
    xfer(1'b1, OFF_ADDR_LO, a);
    xfer(1'b1, OFF_PRED, p);
    xfer(1'b1, OFF_DATA, v);
    xfer(1'b1, OFF_OP, o | 32'h80000000);
    @(posedge clk);
  endtask : run
  task automatic conclude();
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(OFF_FFMASK, "ffmask", 32'hffffffff, '1);
    rd(8'h40, "unmapped", 32'h0, '1);
    xfer(1'b1, OFF_ADDR_HI, $random(seed));
    for (int i = 0; i < 72; i++) begin
      k = 3'(i % 3);
      s = i / 3 % 3;
      be = i / 9 % 2;
      st = i / 18 % 2;
      sg = i / 36;
      mem_addr <= $random(seed);
      @(posedge clk);
      d = mem_data;
      lo = $random(seed) & 32'hfffffff0;
      run(32'(be) << 2, lo, 32'h3, d, 32'(k) | 32'(s) << 4 | 32'(sg) << 6 | 32'(st) << 11);
      rd(OFF_STATUS, "status", 32'h4, k == 0 ? 32'h5 : 32'h1);
      rd(OFF_RESULT, "result", want(k, be, st, sg, s, d), '1);
    end
    for (int i = 0; i < 60; i++) begin
      k = 3'($unsigned($random(seed)) % 3);
      s = $unsigned($random(seed)) % 4;
      lo = $random(seed);
      m = k == 1 ? 4'hf : k == 2 ? 4'h1 : 4'((1 << s) - 1);
      f = (lo[8] || lo[9]) && (k != 0 || lo[10]) && (lo[3:0] & m) != 4'h0;
      run(32'(lo[8]), lo, 32'(lo[10]), lo, 32'(k) | 32'(s) << 4 | 32'(lo[9]) << 8);
      rd(OFF_STATUS, "status", 32'(f), f ? 32'h5 : 32'h1);
    end
    run(32'h2, 32'h8, 32'h0, 32'h0, 32'h80);
    rd(OFF_STATUS, "status", 32'h1, 32'h1);
    run(32'h0, 32'h40, 32'h3, 32'h0, 32'h103);
    rd(OFF_STATUS, "status", 32'h0, 32'h4);
    run(32'h0, 32'h40, 32'h3, 32'h0, 32'h104);
    rd(OFF_STATUS, "status", 32'h2, 32'h6);
    rd(OFF_FFMASK, "ffmask", 32'hfffffffe, '1);
    run(32'h0, 32'h28, 32'h3, mem_data, 32'h125);
    rd(OFF_STATUS, "status", 32'h2004, 32'hff06);
    run(32'h0, 32'h28, 32'h1, ~mem_data, 32'h125);
    rd(OFF_STATUS, "status", 32'h2, 32'h6);
    rd(OFF_FFMASK, "ffmask", 32'hfffffffd, '1);
    rd(OFF_RESULT, "result", mem_data, '1);
    run(32'h0, 32'h80, 32'h3, 32'h0, 32'h700);
    rd(OFF_STATUS, "status", 32'hf004, 32'hff05);
    for (int i = 0; i < 3; i++) begin
      run(32'h0, 32'h0, 32'(i != 1), 32'h0, i == 0 ? 32'h1001 : 32'h1000);
      rd(OFF_STATUS, "status", 32'(i != 1) << 3, 32'h8);
    end
    // Let the monitor take the last data phase before the verdict
    repeat (2) @(posedge clk);
    conclude();
  end
endmodule : tb_top
`default_nettype wire

// ==== testbench/vls_check_checker.sv ====
// Purpose: Port-level checks of the status flags of the vector access checker.
// Assumes: Zero wait states; status settles two edges after the start write.
// Notes:   Register contents are tracked by snooping the bus writes.
`default_nettype none
module vls_check_checker
  import vls_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp
);
  logic        wr_reg, rd_reg;
  logic [1:0]  age_reg;
  logic [7:0]  ad_reg;
  logic [31:0] ctl_reg, lo_reg, op_reg, pr_reg;
  wire logic       ap  = hsel && hready && htrans[1];
  wire logic [2:0] kd  = op_reg[2:0];
  wire logic       on  = ctl_reg[CTRL_ALIGN_BIT] || op_reg[OP_DEVICE_BIT];
  wire logic       mis = (lo_reg[3:0] & 4'((1 << op_reg[OP_SIZE_LSB +: 2]) - 1)) != 4'h0;
  wire logic       flt = hrdata[ST_ALIGN_BIT];
  wire logic       go  = rd_reg && !op_reg[OP_SPBASE_BIT];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {wr_reg, rd_reg, ad_reg, ctl_reg, lo_reg, op_reg, pr_reg} <= '0;
      age_reg <= 2'd3;
    end else begin
      wr_reg <= ap && hwrite;
      // A status read too soon after a start still shows the previous operation
      rd_reg <= ap && !hwrite && haddr == {24'h0, OFF_STATUS} && age_reg != 2'd0;
      ad_reg <= haddr[7:0];
      age_reg <= (wr_reg && ad_reg == OFF_OP && hwdata[OP_START_BIT]) ? 2'd0
               : age_reg + 2'(age_reg != 2'd3);
      if (wr_reg && ad_reg == OFF_CTRL) ctl_reg <= hwdata;
      if (wr_reg && ad_reg == OFF_ADDR_LO) lo_reg <= hwdata;
      if (wr_reg && ad_reg == OFF_OP) op_reg <= hwdata;
      if (wr_reg && ad_reg == OFF_PRED) pr_reg <= hwdata;
    end
  end
  chk_inactive_quiet: assert property (go && kd == K_PRED_ELEM && !pr_reg[0] |-> !flt)
    else $error("inactive element raised an alignment fault");
  chk_elem_size: assert property (go && kd == K_PRED_ELEM && pr_reg[0] |-> flt == (on && mis))
    else $error("element alignment fault wrong for access size");
  chk_vec_base: assert property (go && kd == K_UNPRED_VEC |-> flt == (on && lo_reg[3:0] != 4'h0))
    else $error("vector base alignment fault wrong");
  chk_pred_base: assert property (go && kd == K_UNPRED_PRED |-> flt == (on && lo_reg[0]))
    else $error("predicate base alignment fault wrong");
  chk_stack_base: assert property (rd_reg && op_reg[7] && ctl_reg[1] && lo_reg[3:0] != 4'h0 |-> flt)
    else $error("misaligned stack base not faulted");
  chk_fault_drop: assert property (rd_reg && flt |-> !hrdata[ST_ISSUE_BIT])
    else $error("faulting access was issued");
  chk_nofault_dev: assert property (rd_reg && kd == K_NONFAULT && op_reg[8] && pr_reg[0]
    |-> hrdata[ST_SUPP_BIT] && !hrdata[ST_ISSUE_BIT])
    else $error("non-faulting load reached device memory");
  chk_elem_issue: assert property (go && kd == K_PRED_ELEM && pr_reg[0] && !mis && !op_reg[12]
    |-> hrdata[ST_ISSUE_BIT])
    else $error("aligned active element not issued whole");
endmodule : vls_check_checker
bind vls_check vls_check_checker u_chk (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp);
`default_nettype wire

// ==== testbench/vls_memory_model.sv ====
// Purpose: Memory-side model giving each element address a data word.
// Assumes: Normal memory, reads only, answer available at once.
// Notes:   Every address byte shows in the word, so a stale value cannot pass as new.
`default_nettype none
module vls_memory_model (
  input  wire logic [31:0] addr,
  output logic      [31:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  assign data = {addr[7:0] ^ 8'ha5, addr[31:24], ~addr[15:8], addr[23:16] + 8'h3c};
endmodule : vls_memory_model
`default_nettype wire
